// File: dfr_device.sv
`timescale 1ns/1ps
`include "dfr_consts.svh"

// reset-release synchroniser: clears at once, releases after DEPTH edges
module dfr_rst_sync #(
	parameter int DEPTH = `DFR_SYNC_DEPTH
) (
	// clock and asynchronous clear
	input wire logic clk,
	input wire logic arst_n,
	// released level
	output logic synced_n
);
	// shift chain, stage 0 is the first flip-flop
	typedef struct packed {
		logic [DEPTH-1:0] chain;
	} dfr_sync_state_type;

	dfr_sync_state_type state;
	dfr_sync_state_type next_state;

	// refuse a chain too short to synchronise
	if (DEPTH < 2) begin : gen_bad_depth
		$error("dfr_rst_sync needs DEPTH of at least 2");
	end

	// shift ones in after the clear lifts
	always_comb begin
		next_state = state;
		next_state.chain = {state.chain[DEPTH-2:0], 1'b1};
	end

	// clear takes effect without the clock
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// only the last stage leaves the chain
	assign synced_n = state.chain[DEPTH-1];
endmodule : dfr_rst_sync

// reset control of the fifo pair
module dfr_device #(
	parameter int PTR_WIDTH = 8,
	parameter int OFFSET_WIDTH = 8
) (
	// clock and system reset; both ports run on this clock
	input wire logic pclk,
	input wire logic presetn,
	// link pins
	dfr_link_if.dev link,
	// data path strobes that move the pointers
	input wire logic fifo1_write,
	input wire logic fifo1_read,
	input wire logic fifo2_write,
	input wire logic fifo2_read,
	// mailbox strobes
	input wire logic mail1_write,
	input wire logic mail1_read,
	input wire logic mail2_write,
	input wire logic mail2_read,
	// latched configuration
	output logic big_endian,
	output logic [1:0] flag_select,
	output logic serial_program_mode_n,
	output logic [1:0] fall_through_timing,
	// fifo2 offset registers
	output logic [OFFSET_WIDTH-1:0] fifo2_almost_empty_offset,
	output logic [OFFSET_WIDTH-1:0] fifo2_almost_full_offset,
	// pointers
	output logic [PTR_WIDTH-1:0] fifo1_wr_ptr,
	output logic [PTR_WIDTH-1:0] fifo1_rd_ptr,
	output logic [PTR_WIDTH-1:0] fifo2_wr_ptr,
	output logic [PTR_WIDTH-1:0] fifo2_rd_ptr
);
	// whole state of the block
	typedef struct packed {
		logic [1:0] full_prev; // full reset pins one edge ago
		logic big_endian; // port b ordering
		logic [1:0] flag_sel; // offset method select
		logic spm_n; // serial program mode
		logic [1:0] fall_through; // per fifo timing mode
		logic [OFFSET_WIDTH-1:0] x2; // fifo2 almost-empty offset
		logic [OFFSET_WIDTH-1:0] y2; // fifo2 almost-full offset
		logic [PTR_WIDTH-1:0] wr1;
		logic [PTR_WIDTH-1:0] rd1;
		logic [PTR_WIDTH-1:0] wr2;
		logic [PTR_WIDTH-1:0] rd2;
		logic [1:0] mbx_n; // mailbox flags, high means no message
	} dfr_dev_state_type;

	dfr_dev_state_type state;
	dfr_dev_state_type next_state;

	// refuse widths the logic cannot serve
	if (PTR_WIDTH < 2 || OFFSET_WIDTH < 1) begin : gen_bad_width
		$error("dfr_device width parameters too small");
	end

	// raw reset level of each fifo, either kind
	logic rst1_raw_n;
	logic rst2_raw_n;
	// asynchronous clears of the synchronisers
	logic clr1_n;
	logic clr2_n;
	// released levels per fifo and per port domain
	logic f1_a_n;
	logic f1_b_n;
	logic f2_a_n;
	logic f2_b_n;

	assign rst1_raw_n = link.fifo1_full_reset_n & link.fifo1_limited_reset_n;
	assign rst2_raw_n = link.fifo2_full_reset_n & link.fifo2_limited_reset_n;
	assign clr1_n = presetn & rst1_raw_n;
	assign clr2_n = presetn & rst2_raw_n;

	// fifo1 release into the port a domain
	dfr_rst_sync #(.DEPTH(`DFR_SYNC_DEPTH)) u_sync_1a (
		.clk(pclk),
		.arst_n(clr1_n),
		.synced_n(f1_a_n)
	);
	// fifo1 release into the port b domain
	dfr_rst_sync #(.DEPTH(`DFR_SYNC_DEPTH)) u_sync_1b (
		.clk(pclk),
		.arst_n(clr1_n),
		.synced_n(f1_b_n)
	);
	// fifo2 release into the port a domain
	dfr_rst_sync #(.DEPTH(`DFR_SYNC_DEPTH)) u_sync_2a (
		.clk(pclk),
		.arst_n(clr2_n),
		.synced_n(f2_a_n)
	);
	// fifo2 release into the port b domain
	dfr_rst_sync #(.DEPTH(`DFR_SYNC_DEPTH)) u_sync_2b (
		.clk(pclk),
		.arst_n(clr2_n),
		.synced_n(f2_b_n)
	);

	// next state: configuration capture, offsets, pointers, mailboxes
	always_comb begin
		next_state = state;
		next_state.full_prev = {link.fifo2_full_reset_n, link.fifo1_full_reset_n};
		// track pins while fifo1 full reset is low; last sample is the rising-edge value
		if (!link.fifo1_full_reset_n) begin
			next_state.big_endian = link.endian_timing_select;
			next_state.flag_sel = {link.flag_select_1, link.flag_select_0};
			next_state.spm_n = link.serial_program_mode_n;
		end
		// first edge after full release: high picks standard, low fall-through
		if (link.fifo1_full_reset_n && !state.full_prev[0]) begin
			next_state.fall_through[0] = ~link.endian_timing_select;
		end
		if (link.fifo2_full_reset_n && !state.full_prev[1]) begin
			next_state.fall_through[1] = ~link.endian_timing_select;
			next_state.x2 = '0;
			next_state.y2 = '0;
		end
		// limited resets never touch offsets, method or timing mode
		// fifo1 write pointer lives on port a, read pointer on port b
		if (!f1_a_n) begin
			next_state.wr1 = '0;
		end else if (fifo1_write) begin
			next_state.wr1 = state.wr1 + 1'b1;
		end
		if (!f1_b_n) begin
			next_state.rd1 = '0;
		end else if (fifo1_read) begin
			next_state.rd1 = state.rd1 + 1'b1;
		end
		// fifo2 writes on port b, reads on port a
		if (!f2_b_n) begin
			next_state.wr2 = '0;
		end else if (fifo2_write) begin
			next_state.wr2 = state.wr2 + 1'b1;
		end
		if (!f2_a_n) begin
			next_state.rd2 = '0;
		end else if (fifo2_read) begin
			next_state.rd2 = state.rd2 + 1'b1;
		end
		// mailbox 1: written on port a, read on port b
		if (!f1_a_n || !f1_b_n) begin
			next_state.mbx_n[0] = 1'b1;
		end else if (mail1_write) begin
			next_state.mbx_n[0] = 1'b0;
		end else if (mail1_read) begin
			next_state.mbx_n[0] = 1'b1;
		end
		// mailbox 2: written on port b, read on port a
		if (!f2_a_n || !f2_b_n) begin
			next_state.mbx_n[1] = 1'b1;
		end else if (mail2_write) begin
			next_state.mbx_n[1] = 1'b0;
		end else if (mail2_read) begin
			next_state.mbx_n[1] = 1'b1;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '{
				full_prev: 2'h3, // idle level of the pins, so no false release follows reset
				big_endian: 1'b0,
				flag_sel: 2'h0,
				spm_n: 1'b1,
				fall_through: 2'h0,
				x2: '0,
				y2: '0,
				wr1: '0,
				rd1: '0,
				wr2: '0,
				rd2: '0,
				mbx_n: 2'h3
			};
		end else begin
			state <= next_state;
		end
	end

	// input ready follows the write-side release: two edges after the pin rises
	assign link.port_a_full_or_input_ready = rst1_raw_n & f1_a_n;
	assign link.port_b_full_or_input_ready = rst2_raw_n & f2_b_n;
	// output ready while words are held; low through any reset
	assign link.port_b_empty_or_output_ready = rst1_raw_n & f1_b_n & (state.wr1 != state.rd1);
	assign link.port_a_empty_or_output_ready = rst2_raw_n & f2_a_n & (state.wr2 != state.rd2);
	// almost flags hold their reset levels; thresholds belong to the data path
	assign link.port_b_almost_empty = 1'b0;
	assign link.port_a_almost_empty = 1'b0;
	assign link.port_a_almost_full = 1'b1;
	assign link.port_b_almost_full = 1'b1;
	// mailbox flags go high the moment the pin falls
	assign link.mailbox1_flag_n = state.mbx_n[0] | ~rst1_raw_n;
	assign link.mailbox2_flag_n = state.mbx_n[1] | ~rst2_raw_n;

	// user-side views
	assign big_endian = state.big_endian;
	assign flag_select = state.flag_sel;
	assign serial_program_mode_n = state.spm_n;
	assign fall_through_timing = state.fall_through;
	assign fifo2_almost_empty_offset = state.x2;
	assign fifo2_almost_full_offset = state.y2;
	assign fifo1_wr_ptr = state.wr1;
	assign fifo1_rd_ptr = state.rd1;
	assign fifo2_wr_ptr = state.wr2;
	assign fifo2_rd_ptr = state.rd2;
endmodule : dfr_device

// File: dfr_consts.svh
`ifndef DFR_CONSTS_SVH
`define DFR_CONSTS_SVH

// least number of clock edges a reset pin is held low
`define DFR_HOLD_EDGES 3'd4
// depth of each reset-release synchroniser, in clock edges
`define DFR_SYNC_DEPTH 2

// controller register byte offsets
`define DFR_REG_CTRL 8'h00
`define DFR_REG_CONFIG 8'h04
`define DFR_REG_STATUS 8'h08
`define DFR_REG_MASK 8'h0c

// control register bits (write one to start)
`define DFR_CTRL_FULL 0
`define DFR_CTRL_LIM1 1
`define DFR_CTRL_LIM2 2

// configuration register bits
`define DFR_CFG_ENDIAN 0
`define DFR_CFG_FS0 1
`define DFR_CFG_FS1 2
`define DFR_CFG_SPM_N 3
`define DFR_CFG_TIMING 4
`define DFR_CFG_WIDTH 5
`define DFR_CFG_RESET 5'h18

// status and mask bits
`define DFR_ST_DONE 0
`define DFR_ST_READY1 1
`define DFR_ST_READY2 2
`define DFR_ST_EVENTS 3
`define DFR_ST_BUSY 8
`define DFR_ST_IR1 9
`define DFR_ST_IR2 10
`define DFR_MASK_RESET 3'h0

`endif

// File: dfr_pkg.sv
package dfr_pkg;

	// controller sequencer states
	typedef enum logic [1:0] {
		dfr_idle = 2'b00,
		dfr_hold = 2'b01,
		dfr_wait = 2'b10
	} dfr_host_state_type;

	// configuration levels presented during a full reset
	typedef struct packed {
		logic timing;
		logic spm_n;
		logic fs1;
		logic fs0;
		logic endian;
	} dfr_config_type;

endpackage : dfr_pkg

// File: dfr_link_if.sv
`timescale 1ns/1ps
// pins between the fifo pair and its reset controller
interface dfr_link_if;
	// reset pins, active low
	logic fifo1_full_reset_n;
	logic fifo2_full_reset_n;
	logic fifo1_limited_reset_n;
	logic fifo2_limited_reset_n;
	// configuration pins
	logic endian_timing_select;
	logic flag_select_0;
	logic flag_select_1;
	logic serial_program_mode_n;
	// flags
	logic port_a_full_or_input_ready;
	logic port_b_full_or_input_ready;
	logic port_a_empty_or_output_ready;
	logic port_b_empty_or_output_ready;
	logic port_a_almost_empty;
	logic port_b_almost_empty;
	logic port_a_almost_full;
	logic port_b_almost_full;
	logic mailbox1_flag_n;
	logic mailbox2_flag_n;

	// the fifo pair
	modport dev (
		input fifo1_full_reset_n, fifo2_full_reset_n,
		input fifo1_limited_reset_n, fifo2_limited_reset_n,
		input endian_timing_select, flag_select_0, flag_select_1, serial_program_mode_n,
		output port_a_full_or_input_ready, port_b_full_or_input_ready,
		output port_a_empty_or_output_ready, port_b_empty_or_output_ready,
		output port_a_almost_empty, port_b_almost_empty,
		output port_a_almost_full, port_b_almost_full,
		output mailbox1_flag_n, mailbox2_flag_n
	);

	// the reset controller
	modport host (
		output fifo1_full_reset_n, fifo2_full_reset_n,
		output fifo1_limited_reset_n, fifo2_limited_reset_n,
		output endian_timing_select, flag_select_0, flag_select_1, serial_program_mode_n,
		input port_a_full_or_input_ready, port_b_full_or_input_ready,
		input port_a_empty_or_output_ready, port_b_empty_or_output_ready,
		input port_a_almost_empty, port_b_almost_empty,
		input port_a_almost_full, port_b_almost_full,
		input mailbox1_flag_n, mailbox2_flag_n
	);
endinterface : dfr_link_if

// File: dfr_host.sv
`timescale 1ns/1ps
`include "dfr_consts.svh"

// reset controller: apb registers on one side, the fifo pair's reset pins on the other
module dfr_host (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// link pins
	dfr_link_if.host link
);
	// whole state of the controller
	typedef struct packed {
		dfr_pkg::dfr_host_state_type fsm;
		logic [2:0] cnt; // edges held low so far
		logic [2:0] kind; // which resets are being pulsed
		dfr_pkg::dfr_config_type cfg;
		logic [`DFR_ST_EVENTS-1:0] status; // sticky events
		logic [`DFR_ST_EVENTS-1:0] mask;
		logic [31:0] rdata;
		logic [1:0] ir_prev; // input ready pins one edge ago
		logic full1_n;
		logic full2_n;
		logic lim1_n;
		logic lim2_n;
		logic ets; // endian/timing pin
		logic fs0;
		logic fs1;
		logic spm_n;
	} dfr_host_reg_type;

	dfr_host_reg_type state;
	dfr_host_reg_type next_state;

	logic setup; // first apb cycle
	logic access; // completing apb cycle
	logic mapped;
	logic [1:0] ir_now;

	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign mapped = (paddr == `DFR_REG_CTRL) || (paddr == `DFR_REG_CONFIG) ||
		(paddr == `DFR_REG_STATUS) || (paddr == `DFR_REG_MASK);
	assign ir_now = {link.port_b_full_or_input_ready, link.port_a_full_or_input_ready};

	// sequencer, registers and read data
	always_comb begin
		logic [`DFR_ST_EVENTS-1:0] ev;
		logic [`DFR_ST_EVENTS-1:0] clr;
		ev = '0;
		clr = '0;
		next_state = state;
		next_state.ir_prev = ir_now;
		// each input ready rising is an event
		ev[`DFR_ST_READY1] = ir_now[0] & ~state.ir_prev[0];
		ev[`DFR_ST_READY2] = ir_now[1] & ~state.ir_prev[1];
		unique case (state.fsm)
			dfr_pkg::dfr_idle: begin
				// a start is taken only when idle
				if (access && pwrite && paddr == `DFR_REG_CTRL && |pwdata[2:0]) begin
					next_state.fsm = dfr_pkg::dfr_hold;
					next_state.cnt = 3'h0;
					next_state.kind = pwdata[2:0];
					if (pwdata[`DFR_CTRL_FULL]) begin
						// both full resets fall together, configuration on the pins
						next_state.full1_n = 1'b0;
						next_state.full2_n = 1'b0;
						next_state.ets = state.cfg.endian;
						next_state.fs0 = state.cfg.fs0;
						next_state.fs1 = state.cfg.fs1;
						next_state.spm_n = state.cfg.spm_n;
					end
					next_state.lim1_n = ~pwdata[`DFR_CTRL_LIM1];
					next_state.lim2_n = ~pwdata[`DFR_CTRL_LIM2];
				end
			end
			dfr_pkg::dfr_hold: begin
				next_state.cnt = state.cnt + 3'h1;
				// release after the fourth edge with the pins low
				if (state.cnt == `DFR_HOLD_EDGES - 3'h1) begin
					next_state.full1_n = 1'b1;
					next_state.full2_n = 1'b1;
					next_state.lim1_n = 1'b1;
					next_state.lim2_n = 1'b1;
					if (state.kind[`DFR_CTRL_FULL]) begin
						next_state.ets = state.cfg.timing;
					end
					next_state.fsm = dfr_pkg::dfr_wait;
				end
			end
			dfr_pkg::dfr_wait: begin
				// done when the reset fifos accept writes again
				if ((!(state.kind[`DFR_CTRL_FULL] | state.kind[`DFR_CTRL_LIM1]) || ir_now[0]) &&
					(!(state.kind[`DFR_CTRL_FULL] | state.kind[`DFR_CTRL_LIM2]) || ir_now[1])) begin
					ev[`DFR_ST_DONE] = 1'b1;
					next_state.fsm = dfr_pkg::dfr_idle;
				end
			end
			default: begin
				next_state.fsm = dfr_pkg::dfr_idle;
			end
		endcase
		// register writes
		if (access && pwrite && paddr == `DFR_REG_CONFIG) begin
			next_state.cfg = pwdata[`DFR_CFG_WIDTH-1:0];
		end
		if (access && pwrite && paddr == `DFR_REG_MASK) begin
			next_state.mask = pwdata[`DFR_ST_EVENTS-1:0];
		end
		// a read of status clears only what it returned, so an event landing at the
		// setup edge is reported by the next read instead of being lost
		if (access && !pwrite && paddr == `DFR_REG_STATUS) begin
			clr = state.rdata[`DFR_ST_EVENTS-1:0];
		end
		next_state.status = (state.status & ~clr) | ev;
		// read data prepared in the setup cycle
		if (setup && !pwrite) begin
			next_state.rdata = 32'h0;
			unique case (paddr)
				`DFR_REG_CONFIG: next_state.rdata[`DFR_CFG_WIDTH-1:0] = state.cfg;
				`DFR_REG_MASK: next_state.rdata[`DFR_ST_EVENTS-1:0] = state.mask;
				`DFR_REG_STATUS: begin
					next_state.rdata[`DFR_ST_EVENTS-1:0] = state.status;
					next_state.rdata[`DFR_ST_BUSY] = (state.fsm != dfr_pkg::dfr_idle);
					next_state.rdata[`DFR_ST_IR1] = ir_now[0];
					next_state.rdata[`DFR_ST_IR2] = ir_now[1];
				end
				default: next_state.rdata = 32'h0;
			endcase
		end
	end

	// state register; power-up starts with both full resets low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '{
				fsm: dfr_pkg::dfr_hold,
				cnt: 3'h0,
				kind: 3'h1,
				cfg: `DFR_CFG_RESET,
				status: 3'h0,
				mask: `DFR_MASK_RESET,
				rdata: 32'h0,
				ir_prev: 2'h0,
				full1_n: 1'b0,
				full2_n: 1'b0,
				lim1_n: 1'b1,
				lim2_n: 1'b1,
				ets: 1'b0,
				fs0: 1'b0,
				fs1: 1'b0,
				spm_n: 1'b1
			};
		end else begin
			state <= next_state;
		end
	end

	// apb answers in the access cycle
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = state.rdata;
	assign irq = |(state.status & state.mask);
	// pins
	assign link.fifo1_full_reset_n = state.full1_n;
	assign link.fifo2_full_reset_n = state.full2_n;
	assign link.fifo1_limited_reset_n = state.lim1_n;
	assign link.fifo2_limited_reset_n = state.lim2_n;
	assign link.endian_timing_select = state.ets;
	assign link.flag_select_0 = state.fs0;
	assign link.flag_select_1 = state.fs1;
	assign link.serial_program_mode_n = state.spm_n;
endmodule : dfr_host

// File: dfr_link_chk.sv
`timescale 1ns/1ps
// watches the reset pins and the flags between the fifo pair and its controller
module dfr_link_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// reset pins
	input wire logic fifo1_full_reset_n,
	input wire logic fifo2_full_reset_n,
	input wire logic fifo1_limited_reset_n,
	input wire logic fifo2_limited_reset_n,
	// flags
	input wire logic port_a_full_or_input_ready,
	input wire logic port_b_full_or_input_ready,
	input wire logic port_b_empty_or_output_ready,
	input wire logic port_a_almost_empty,
	input wire logic port_b_almost_empty,
	input wire logic port_a_almost_full,
	input wire logic port_b_almost_full,
	input wire logic mailbox1_flag_n,
	input wire logic mailbox2_flag_n
);
	// a fifo is out of reset only while both of its pins are high
	wire f1_ok = fifo1_full_reset_n & fifo1_limited_reset_n;
	wire f2_ok = fifo2_full_reset_n & fifo2_limited_reset_n;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// a low fifo1 pin forces its flags in the same cycle
	property p_f1_flags;
		!f1_ok |-> !port_a_full_or_input_ready && !port_b_almost_empty && port_a_almost_full
			&& mailbox1_flag_n;
	endproperty
	a_f1_flags: assert property (p_f1_flags) else $error("fifo1 flags not forced");

	// a low fifo2 pin forces its flags in the same cycle
	property p_f2_flags;
		!f2_ok |-> !port_b_full_or_input_ready && !port_a_almost_empty && port_b_almost_full
			&& mailbox2_flag_n;
	endproperty
	a_f2_flags: assert property (p_f2_flags) else $error("fifo2 flags not forced");

	// a released fifo1 shows no words before its first write can land
	property p_f1_clear;
		$rose(f1_ok) |-> ##2 !port_b_empty_or_output_ready;
	endproperty
	a_f1_clear: assert property (p_f1_clear) else $error("fifo1 not emptied");

	// input ready stays low two cycles after release, then rises
	property p_f1_ready;
		$rose(f1_ok) |-> !port_a_full_or_input_ready ##1 !port_a_full_or_input_ready
			##1 port_a_full_or_input_ready;
	endproperty
	a_f1_ready: assert property (p_f1_ready) else $error("fifo1 ready timing");

	property p_f2_ready;
		$rose(f2_ok) |-> !port_b_full_or_input_ready ##1 !port_b_full_or_input_ready
			##1 port_b_full_or_input_ready;
	endproperty
	a_f2_ready: assert property (p_f2_ready) else $error("fifo2 ready timing");

	// fifo1 full reset pulse spans at least four edges
	property p_full_hold;
		$fell(fifo1_full_reset_n) |-> !fifo1_full_reset_n [*4];
	endproperty
	a_full_hold: assert property (p_full_hold) else $error("full reset too short");

	// fifo1 limited reset pulse spans at least four edges
	property p_lim_hold;
		$fell(fifo1_limited_reset_n) |-> !fifo1_limited_reset_n [*4];
	endproperty
	a_lim_hold: assert property (p_lim_hold) else $error("limited reset too short");

	// both full resets start together
	property p_full_fall;
		$fell(fifo1_full_reset_n) |-> $fell(fifo2_full_reset_n);
	endproperty
	a_full_fall: assert property (p_full_fall) else $error("full resets apart");

	// both full resets end together so the configuration latches
	property p_full_rise;
		$rose(fifo1_full_reset_n) |-> $rose(fifo2_full_reset_n);
	endproperty
	a_full_rise: assert property (p_full_rise) else $error("full releases apart");
endmodule : dfr_link_chk

// File: tb_dual_fifo_reset_control.sv
`timescale 1ns/1ps
// drives the controller over apb and the fifo pair's strobes, checks both ends
module tb_dual_fifo_reset_control;
	// clock, reset and apb
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, irq;
	// strobes: fifo1 wr/rd, fifo2 wr/rd, mail1 wr/rd, mail2 wr/rd
	logic [7:0] strb = 8'h00;
	// latched configuration, offsets and pointers
	logic be, spm_n;
	logic [1:0] fsel, ftt;
	logic [7:0] x_off, y_off, w1, r1, w2, r2;
	// bookkeeping
	int num_errors = 0;
	int checked = 0;
	logic [31:0] rd;
	logic err;

	dfr_link_if link ();
	dfr_host i_dfr_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
	dfr_device i_dfr_device (.pclk(pclk), .presetn(presetn), .link(link),
		.fifo1_write(strb[0]), .fifo1_read(strb[1]), .fifo2_write(strb[2]),
		.fifo2_read(strb[3]), .mail1_write(strb[4]), .mail1_read(strb[5]),
		.mail2_write(strb[6]), .mail2_read(strb[7]), .big_endian(be), .flag_select(fsel),
		.serial_program_mode_n(spm_n), .fall_through_timing(ftt),
		.fifo2_almost_empty_offset(x_off), .fifo2_almost_full_offset(y_off),
		.fifo1_wr_ptr(w1), .fifo1_rd_ptr(r1), .fifo2_wr_ptr(w2), .fifo2_rd_ptr(r2));
	dfr_link_chk i_dfr_link_chk (.pclk(pclk), .presetn(presetn),
		.fifo1_full_reset_n(link.fifo1_full_reset_n),
		.fifo2_full_reset_n(link.fifo2_full_reset_n),
		.fifo1_limited_reset_n(link.fifo1_limited_reset_n),
		.fifo2_limited_reset_n(link.fifo2_limited_reset_n),
		.port_a_full_or_input_ready(link.port_a_full_or_input_ready),
		.port_b_full_or_input_ready(link.port_b_full_or_input_ready),
		.port_b_empty_or_output_ready(link.port_b_empty_or_output_ready),
		.port_a_almost_empty(link.port_a_almost_empty),
		.port_b_almost_empty(link.port_b_almost_empty),
		.port_a_almost_full(link.port_a_almost_full),
		.port_b_almost_full(link.port_b_almost_full),
		.mailbox1_flag_n(link.mailbox1_flag_n), .mailbox2_flag_n(link.mailbox2_flag_n));

	// 250 mhz clock
	always #2 pclk = ~pclk;

	// prints the counts and the verdict, then ends the run
	task stop_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	// compares one result
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer; read data and error taken at the accepting edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// reads a register and compares it
	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	// one-cycle strobe pulse on the device's user side
	task strobe(input logic [7:0] s);
		@(posedge pclk);
		strb <= s;
		@(posedge pclk);
		strb <= 8'h00;
	endtask : strobe

	// flags as ira irb eora eorb aea aeb afa afb mbx1 mbx2
	task fchk(input logic [31:0] exp);
		chk({22'h0, link.port_a_full_or_input_ready, link.port_b_full_or_input_ready,
			link.port_a_empty_or_output_ready, link.port_b_empty_or_output_ready,
			link.port_a_almost_empty, link.port_b_almost_empty, link.port_a_almost_full,
			link.port_b_almost_full, link.mailbox1_flag_n, link.mailbox2_flag_n}, exp);
	endtask : fchk

	// waits, bounded, until both fifos take writes and the sequence has closed
	task wait_idle;
		int n;
		n = 0;
		@(posedge pclk);
		while (!(link.port_a_full_or_input_ready === 1'b1
			&& link.port_b_full_or_input_ready === 1'b1) && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 50) num_errors++;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
	endtask : wait_idle

	// watchdog
	initial begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		stop_test;
	end

	// main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle;
		// power-up reset: little endian, standard timing, masked events
		fchk(32'h30f);
		chk({26'h0, be, fsel, spm_n, ftt}, 32'h04);
		chk({31'h0, irq}, 32'h0);
		rchk(8'h04, 32'h18);
		rchk(8'h0c, 32'h0);
		rchk(8'h00, 32'h0);
		rchk(8'h08, 32'h607);
		rchk(8'h08, 32'h600);
		apb(1'b0, 8'h10, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// fill both fifos and mailboxes, then full reset with a new configuration
		strobe(8'h01);
		strobe(8'h01);
		strobe(8'h04);
		strobe(8'h50);
		@(negedge pclk);
		fchk(32'h3cc);
		// read one word of fifo1 and its mailbox
		strobe(8'h22);
		@(negedge pclk);
		fchk(32'h3ce);
		apb(1'b1, 8'h04, 32'h03);
		apb(1'b1, 8'h00, 32'h1);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		fchk(32'h00f);
		wait_idle;
		fchk(32'h30f);
		chk({26'h0, be, fsel, spm_n, ftt}, 32'h2b);
		chk({16'h0, x_off, y_off}, 32'h0);
		chk({w1, r1, w2, r2}, 32'h0);
		// limited reset of fifo1 with the done event unmasked
		apb(1'b1, 8'h0c, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		strobe(8'h01);
		strobe(8'h04);
		strobe(8'h50);
		apb(1'b1, 8'h04, 32'h18);
		apb(1'b1, 8'h00, 32'h2);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		fchk(32'h18e);
		wait_idle;
		fchk(32'h38e);
		chk({16'h0, w1, r1}, 32'h0);
		chk({26'h0, be, fsel, spm_n, ftt}, 32'h2b);
		chk({31'h0, irq}, 32'h1);
		rchk(8'h08, 32'h603);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		// limited reset of both; a full reset ordered while busy is dropped
		// read fifo2's word and its mailbox before resetting it
		strobe(8'h88);
		@(negedge pclk);
		fchk(32'h30f);
		apb(1'b1, 8'h00, 32'h6);
		apb(1'b1, 8'h00, 32'h1);
		wait_idle;
		fchk(32'h30f);
		chk({26'h0, be, fsel, spm_n, ftt}, 32'h2b);
		chk({w1, r1, w2, r2}, 32'h0);
		// mid-run system reset restarts the power-up sequence
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_idle;
		fchk(32'h30f);
		chk({26'h0, be, fsel, spm_n, ftt}, 32'h04);
		rchk(8'h0c, 32'h0);
		rchk(8'h08, 32'h607);
		stop_test;
	end
endmodule : tb_dual_fifo_reset_control
